// ==== hdl/jtag_consts.vh ====
// Constants for the flash readback and boundary-scan test port.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef JTAG_CONSTS_VH
`define JTAG_CONSTS_VH

// ****************************************
// Instruction register
// ****************************************
`define IR_LEN 6
`define IR_CAPTURE 6'h01
`define IR_BYPASS 6'h3F
`define INSTR_FLASH_ACCESS 6'h01
`define INSTR_RX_READBACK 6'h03
`define INSTR_BUSY_QUERY 6'h04
`define INSTR_TEST_MODE 6'h20
`define INSTR_SAMPLE_PRELOAD 6'h3D
`define INSTR_EXTEST 6'h3E

// ****************************************
// Data register lengths minus one; BSR_LEN is the full chain length
// ****************************************
`define BSR_LEN 317
`define DRL_READBACK 9'h020
`define DRL_BUSY 9'h000
`define DRL_TEST_MODE 9'h001
`define DRL_BSR 9'h13C
`define DRL_BYPASS 9'h000

// ****************************************
// Test-mode register values
// ****************************************
`define TM_DISABLED 2'h0
`define TM_BOUNDARY 2'h3

// ****************************************
// Test access port state bit positions
// ****************************************
`define ST_RESET 0
`define ST_IDLE 1
`define ST_SEL_DR 2
`define ST_CAP_DR 3
`define ST_SH_DR 4
`define ST_EX1_DR 5
`define ST_PA_DR 6
`define ST_EX2_DR 7
`define ST_UPD_DR 8
`define ST_SEL_IR 9
`define ST_CAP_IR 10
`define ST_SH_IR 11
`define ST_EX1_IR 12
`define ST_PA_IR 13
`define ST_EX2_IR 14
`define ST_UPD_IR 15
`define ST_COUNT 16

`endif

// ==== hdl/tap_fsm.v ====
// Test access port state machine, stepped once per detected test clock rise.
// Assumes tck_rise and tms are already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "jtag_consts.vh"

module tap_fsm (
    input wire clk,
    input wire reset,
    input wire tck_rise,
    input wire tms,
    output reg [`ST_COUNT-1:0] state_r
);

    // ****************************************
    // One-hot state codes
    // ****************************************
    localparam [`ST_COUNT-1:0] RST = 16'h0001;
    localparam [`ST_COUNT-1:0] IDL = 16'h0002;
    localparam [`ST_COUNT-1:0] SDR = 16'h0004;
    localparam [`ST_COUNT-1:0] CDR = 16'h0008;
    localparam [`ST_COUNT-1:0] HDR = 16'h0010;
    localparam [`ST_COUNT-1:0] E1D = 16'h0020;
    localparam [`ST_COUNT-1:0] PDR = 16'h0040;
    localparam [`ST_COUNT-1:0] E2D = 16'h0080;
    localparam [`ST_COUNT-1:0] UDR = 16'h0100;
    localparam [`ST_COUNT-1:0] SIR = 16'h0200;
    localparam [`ST_COUNT-1:0] CIR = 16'h0400;
    localparam [`ST_COUNT-1:0] HIR = 16'h0800;
    localparam [`ST_COUNT-1:0] E1I = 16'h1000;
    localparam [`ST_COUNT-1:0] PIR = 16'h2000;
    localparam [`ST_COUNT-1:0] E2I = 16'h4000;
    localparam [`ST_COUNT-1:0] UIR = 16'h8000;

    reg [`ST_COUNT-1:0] state_nxt;

    // Standard sixteen-state walk; an illegal code falls back to reset.
    always @* begin
        case (state_r)
            RST: state_nxt = tms ? RST : IDL;
            IDL: state_nxt = tms ? SDR : IDL;
            SDR: state_nxt = tms ? SIR : CDR;
            CDR: state_nxt = tms ? E1D : HDR;
            HDR: state_nxt = tms ? E1D : HDR;
            E1D: state_nxt = tms ? UDR : PDR;
            PDR: state_nxt = tms ? E2D : PDR;
            E2D: state_nxt = tms ? UDR : HDR;
            UDR: state_nxt = tms ? SDR : IDL;
            SIR: state_nxt = tms ? RST : CIR;
            CIR: state_nxt = tms ? E1I : HIR;
            HIR: state_nxt = tms ? E1I : HIR;
            E1I: state_nxt = tms ? UIR : PIR;
            PIR: state_nxt = tms ? E2I : PIR;
            E2I: state_nxt = tms ? UIR : HIR;
            UIR: state_nxt = tms ? SDR : IDL;
            default: state_nxt = RST;
        endcase
    end

    // The state only moves on a test clock rise.
    always @(posedge clk) begin
        if (reset) begin
            state_r <= RST;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

endmodule // tap_fsm

`default_nettype wire

// ==== hdl/jtag_flash_bscan.v ====
// Test port with flash readback, busy query, test-mode and boundary-scan instructions.
// Assumes the flash controller and core logic run on clk; test pins and pads are asynchronous.
// Operation
// - Instruction 0x03 reads back flash data over 33 bits; input bits ignored.
// - Readback bits 32..1 hold the flash word, bit 0 the valid flag.
// - Valid flag is set only when the previous command was flash access.
// - Instruction 0x04 shifts one bit: 0 idle, 1 busy; input ignored.
// - Sample captures pin states in capture-DR without disturbing the pins.
// - The captured snapshot shifts out on the test data output.
// - Preload shifts a host pattern into the cells without touching the core.
// - Sample and preload share code 0x3D over a 317-bit chain.
// - External test drives output pins from cells and captures input pins.
// - External test is code 0x3E, 317 bits; input bits ignored.
// - The boundary chain is one serial chain of exactly 317 cells.
// - Instruction 0x20 loads the two-bit test-mode: 00 off, 11 boundary test.
// - Boundary instructions act only while test-mode holds 11.
// - One flash access returns at most 32 bits, delivered by the readback.
`timescale 1ns/1ps
`default_nettype none
`include "jtag_consts.vh"

module jtag_flash_bscan #(
    parameter BSR_LEN = `BSR_LEN,
    parameter [`BSR_LEN-1:0] OUT_CELL_MASK = {`BSR_LEN{1'b0}}
) (
    input wire clk,
    input wire reset,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo_r,
    output reg tdo_oe_n_r,
    input wire flash_busy,
    input wire [31:0] flash_rx_data,
    input wire [BSR_LEN-1:0] core_out,
    input wire [BSR_LEN-1:0] pad_in,
    output reg [BSR_LEN-1:0] pad_out_r,
    output wire [BSR_LEN-1:0] core_in,
    output wire [1:0] test_mode,
    output wire extest_active
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg [2:0] tp_meta_r;
    reg [2:0] tp_sync_r;
    reg tck_prev_r;
    reg [BSR_LEN-1:0] pad_meta_r;
    reg [BSR_LEN-1:0] pad_sync_r;
    wire tck_rise;
    wire tck_fall;

    // Two flops on every pin; edges are found only on the second stage.
    always @(posedge clk) begin
        if (reset) begin
            tp_meta_r <= 3'h0;
            tp_sync_r <= 3'h0;
            tck_prev_r <= 1'b0;
            pad_meta_r <= {BSR_LEN{1'b0}};
            pad_sync_r <= {BSR_LEN{1'b0}};
        end else begin
            tp_meta_r <= {tck, tms, tdi};
            tp_sync_r <= tp_meta_r;
            tck_prev_r <= tp_sync_r[2];
            pad_meta_r <= pad_in;
            pad_sync_r <= pad_meta_r;
        end
    end

    assign tck_rise = tp_sync_r[2] & ~tck_prev_r;
    assign tck_fall = ~tp_sync_r[2] & tck_prev_r;

    // ****************************************
    // State machine
    // ****************************************
    wire [`ST_COUNT-1:0] st;

    tap_fsm u_tap (
        .clk(clk),
        .reset(reset),
        .tck_rise(tck_rise),
        .tms(tp_sync_r[1]),
        .state_r(st)
    );

    // ****************************************
    // Instruction register and decode
    // ****************************************
    reg [`IR_LEN-1:0] ir_sr_r;
    reg [`IR_LEN-1:0] ir_r;
    reg prev_access_r;
    reg [1:0] tm_r;
    wire bs_ok;
    wire sel_readback;
    wire sel_busy;
    wire sel_tm;
    wire sel_sp;
    wire sel_ext;

    // Boundary instructions fall back to bypass unless test-mode is 11.
    assign bs_ok = (tm_r == `TM_BOUNDARY);
    assign sel_readback = (ir_r == `INSTR_RX_READBACK);
    assign sel_busy = (ir_r == `INSTR_BUSY_QUERY);
    assign sel_tm = (ir_r == `INSTR_TEST_MODE);
    assign sel_sp = (ir_r == `INSTR_SAMPLE_PRELOAD) & bs_ok;
    assign sel_ext = (ir_r == `INSTR_EXTEST) & bs_ok;
    assign test_mode = tm_r;
    assign extest_active = sel_ext;

    // The instruction takes effect at update-IR; the previous one is remembered for the valid flag.
    always @(posedge clk) begin
        if (reset) begin
            ir_sr_r <= `IR_CAPTURE;
            ir_r <= `IR_BYPASS;
            prev_access_r <= 1'b0;
        end else if (tck_rise) begin
            if (st[`ST_RESET]) begin
                ir_r <= `IR_BYPASS;
                prev_access_r <= 1'b0;
            end else if (st[`ST_CAP_IR]) begin
                ir_sr_r <= `IR_CAPTURE;
            end else if (st[`ST_SH_IR]) begin
                ir_sr_r <= {tp_sync_r[0], ir_sr_r[`IR_LEN-1:1]};
            end else if (st[`ST_UPD_IR]) begin
                ir_r <= ir_sr_r;
                prev_access_r <= (ir_r == `INSTR_FLASH_ACCESS);
            end
        end
    end

    // ****************************************
    // Data register shift path
    // ****************************************
    reg [BSR_LEN-1:0] dr_sr_r;
    reg [BSR_LEN-1:0] dr_nxt;
    reg [BSR_LEN-1:0] cap_vec;
    reg [8:0] dr_top;
    reg dr_in;
    wire [BSR_LEN-1:0] bs_cap;

    // Output cells see the core's value, input cells the pad level.
    genvar gi;
    generate
        for (gi = 0; gi < BSR_LEN; gi = gi + 1) begin : g_cell
            assign bs_cap[gi] = OUT_CELL_MASK[gi] ? core_out[gi] : pad_sync_r[gi];
        end
    endgenerate

    // Length and captured value follow the selected instruction.
    always @* begin
        cap_vec = {BSR_LEN{1'b0}};
        dr_in = 1'b0;
        if (sel_readback) begin
            dr_top = `DRL_READBACK;
            cap_vec[32:0] = {flash_rx_data, prev_access_r};
        end else if (sel_busy) begin
            dr_top = `DRL_BUSY;
            cap_vec[0] = flash_busy;
        end else if (sel_tm) begin
            dr_top = `DRL_TEST_MODE;
            dr_in = tp_sync_r[0];
        end else if (sel_sp | sel_ext) begin
            dr_top = `DRL_BSR;
            cap_vec = bs_cap;
            dr_in = sel_sp & tp_sync_r[0];
        end else begin
            dr_top = `DRL_BYPASS;
        end
        dr_nxt = {1'b0, dr_sr_r[BSR_LEN-1:1]};
        dr_nxt[dr_top] = dr_in;
    end

    // Capture at capture-DR, shift toward bit 0 in shift-DR.
    always @(posedge clk) begin
        if (reset) begin
            dr_sr_r <= {BSR_LEN{1'b0}};
        end else if (tck_rise) begin
            if (st[`ST_CAP_DR]) begin
                dr_sr_r <= cap_vec;
            end else if (st[`ST_SH_DR]) begin
                dr_sr_r <= dr_nxt;
            end
        end
    end

    // ****************************************
    // Update registers
    // ****************************************
    reg [BSR_LEN-1:0] bs_hold_r;

    // Only sample-preload loads the hold cells; external test ignores shifted-in data.
    always @(posedge clk) begin
        if (reset) begin
            tm_r <= `TM_DISABLED;
            bs_hold_r <= {BSR_LEN{1'b0}};
        end else if (tck_rise) begin
            if (st[`ST_RESET]) begin
                tm_r <= `TM_DISABLED;
            end else if (st[`ST_UPD_DR] & sel_tm) begin
                tm_r <= dr_sr_r[1:0];
            end else if (st[`ST_UPD_DR] & sel_sp) begin
                bs_hold_r <= dr_sr_r;
            end
        end
    end

    // Pads follow the core except under external test, when the hold cells drive every pad.
    always @(posedge clk) begin
        if (reset) begin
            pad_out_r <= {BSR_LEN{1'b0}};
        end else if (sel_ext) begin
            pad_out_r <= bs_hold_r;
        end else begin
            pad_out_r <= core_out;
        end
    end

    // The core always sees the pads; preload never disturbs it.
    assign core_in = pad_sync_r;

    // ****************************************
    // Test data output
    // ****************************************
    // Changes on the falling test clock so the host samples a settled bit on the rise.
    always @(posedge clk) begin
        if (reset) begin
            tdo_r <= 1'b0;
            tdo_oe_n_r <= 1'b1;
        end else if (tck_fall) begin
            if (st[`ST_SH_DR]) begin
                tdo_r <= dr_sr_r[0];
                tdo_oe_n_r <= 1'b0;
            end else if (st[`ST_SH_IR]) begin
                tdo_r <= ir_sr_r[0];
                tdo_oe_n_r <= 1'b0;
            end else begin
                tdo_r <= 1'b0;
                tdo_oe_n_r <= 1'b1;
            end
        end
    end

endmodule // jtag_flash_bscan

`default_nettype wire

// ==== testbench/jtag_host.sv ====
// Host model for the test link: drives the test clock, mode select and data in.
// Assumes clk is the design clock; one test clock period is eight clk cycles.
`timescale 1ns/1ps
`default_nettype none
module jtag_host (
    input wire logic clk,
    input wire logic tdo,
    output var logic tck,
    output var logic tms,
    output var logic tdi
);
    // ********************
    // Link stepping
    // ********************
    // The link idles with mode select high, so the port rests in its reset state.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One test clock period; tdo is read late in the high phase, where it has settled.
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        tck <= 1'b1;
        // Three edges here; the next call's first wait is the eighth, keeping the period at 400 ns.
        repeat (3) @(posedge clk);
        q = tdo;
    endtask

    // Walk from idle through one scan, low bit first, and back to idle via update.
    // Data in is toggled outside shifting, so a stale level never looks like data.
    task automatic scan(input logic ir, input int n, input logic [316:0] din, output logic [316:0] dout);
        logic q;
        dout = {317{1'b0}};
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], q);
            dout[k] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        // Let the update reach the pads before the caller looks; the test clock stands high meanwhile.
        repeat (3) @(posedge clk);
    endtask

    // Five high mode-select rises reach the reset state, then one low rise to idle.
    task automatic tlr();
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule // jtag_host
`default_nettype wire

// ==== testbench/jtag_flash_bscan_assertions.sv ====
// Checker for the test port; it watches only the top-level ports.
// Assumes one clock, clk, and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module jtag_flash_bscan_checker #(
    parameter BSR_LEN = 317
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tck,
    input wire logic tdo_r,
    input wire logic tdo_oe_n_r,
    input wire logic [BSR_LEN-1:0] core_out,
    input wire logic [BSR_LEN-1:0] pad_in,
    input wire logic [BSR_LEN-1:0] pad_out_r,
    input wire logic [BSR_LEN-1:0] core_in,
    input wire logic [1:0] test_mode,
    input wire logic extest_active
);
    // ********************
    // Port relations
    // ********************
    // Link edges reach clk after three to four cycles of synchronising.
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_mode_reset_clear: assert property (disable iff (1'b0) reset |=> test_mode == 2'b00)
        else $error("test mode not cleared by reset");
    a_extest_needs_mode: assert property (extest_active |-> test_mode == 2'b11)
        else $error("external test active without boundary mode");
    a_pads_follow_core: assert property (!extest_active |=> pad_out_r == $past(core_out))
        else $error("pads do not follow the core");
    a_core_sees_pads: assert property (!$past(reset) && !$past(reset, 2) |-> core_in == $past(pad_in, 2))
        else $error("core input disturbed");
    a_tdo_after_fall: assert property ($changed(tdo_r) && $stable(tdo_oe_n_r) |-> !$past(tck, 3) || !$past(tck, 4))
        else $error("tdo moved away from a falling test clock");
    a_mode_after_rise: assert property ($changed(test_mode) |-> $past(tck, 3) || $past(tck, 4))
        else $error("test mode moved away from a rising test clock");
    a_extest_after_rise: assert property ($rose(extest_active) |-> $past(tck, 3) || $past(tck, 4))
        else $error("external test began away from a rising test clock");
    a_pads_hold_extest: assert property ($past(extest_active) && $past(extest_active, 2) |-> $stable(pad_out_r))
        else $error("pads moved under external test");
endmodule // jtag_flash_bscan_checker
bind jtag_flash_bscan jtag_flash_bscan_checker #(.BSR_LEN(BSR_LEN)) u_jtag_flash_bscan_checker (
    .clk(clk), .reset(reset), .tck(tck), .tdo_r(tdo_r), .tdo_oe_n_r(tdo_oe_n_r),
    .core_out(core_out), .pad_in(pad_in), .pad_out_r(pad_out_r), .core_in(core_in),
    .test_mode(test_mode), .extest_active(extest_active)
);
`default_nettype wire

// ==== testbench/tb_jtag_flash_bscan.sv ====
// Self-checking bench for the test port, with the host model on the link.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_flash_bscan;
    localparam int N = 317;
    localparam logic [N-1:0] MASK = 317'h0000_00FF; // Cells 0 to 7 are output cells.
    localparam logic [N-1:0] PAD = N'({80{4'h6}});
    localparam logic [N-1:0] PRE = N'({80{4'hC}});
    typedef struct packed {logic [5:0] code; logic busy; logic exp;} row_t;
    // Busy query both ways, readback after a non-flash command, boundary codes in mode 00.
    row_t rows [5] = '{'{6'h04, 1'b0, 1'b0}, '{6'h04, 1'b1, 1'b1}, '{6'h03, 1'b1, 1'b0},
                       '{6'h3D, 1'b0, 1'b0}, '{6'h3E, 1'b0, 1'b0}};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic flash_busy = 1'b0;
    logic [31:0] flash_rx_data = 32'h0000_0000;
    // Core drives ones, so a boundary code that wrongly acts in mode 00 shows a one in bit 0.
    logic [N-1:0] core_out = {N{1'b1}};
    logic [N-1:0] pad_in = {N{1'b0}};
    logic tck, tms, tdi, tdo_r, tdo_oe_n_r, extest_active;
    logic [N-1:0] pad_out_r, core_in, got;
    logic [1:0] test_mode;
    int mismatches = 0;
    int num_checks = 0;

    // ********************
    // Harness
    // ********************
    // Free-running 20 MHz clock.
    always #25 clk = ~clk;

    jtag_host u_jtag_host (.clk(clk), .tdo(tdo_r), .tck(tck), .tms(tms), .tdi(tdi));
    jtag_flash_bscan #(.OUT_CELL_MASK(MASK)) u_jtag_flash_bscan (
        .clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo_r(tdo_r),
        .tdo_oe_n_r(tdo_oe_n_r), .flash_busy(flash_busy), .flash_rx_data(flash_rx_data),
        .core_out(core_out), .pad_in(pad_in), .pad_out_r(pad_out_r), .core_in(core_in),
        .test_mode(test_mode), .extest_active(extest_active));

    // Case equality, so an unknown never passes for a match.
    task automatic check(input string what, input logic [N-1:0] exp, input logic [N-1:0] seen);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Table rows first, then readback, boundary scan and mode handling by hand.
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check("test_mode", N'(2'b00), N'(test_mode));
        check("tdo_oe_n_r", N'(1'b1), N'(tdo_oe_n_r));
        // The host idles with mode select high, so the port sits in its reset state until walked to idle.
        u_jtag_host.tlr();
        foreach (rows[i]) begin
            @(posedge clk);
            flash_busy <= rows[i].busy;
            u_jtag_host.scan(1'b1, 6, N'(rows[i].code), got);
            u_jtag_host.scan(1'b0, 2, {N{1'b1}}, got);
            check("row bit 0", N'(rows[i].exp), N'(got[0]));
        end
        @(posedge clk);
        flash_rx_data <= 32'hA5C3_0F96;
        // The host confirms an idle controller before the flash access.
        u_jtag_host.scan(1'b1, 6, N'(6'h04), got);
        u_jtag_host.scan(1'b0, 1, {N{1'b1}}, got);
        check("busy before access", N'(1'b0), N'(got[0]));
        u_jtag_host.scan(1'b1, 6, N'(6'h01), got);
        u_jtag_host.scan(1'b1, 6, N'(6'h03), got);
        // The second readback shows the flash word and valid flag hold across repeated scans.
        repeat (2) begin
            u_jtag_host.scan(1'b0, 33, {N{1'b1}}, got);
            check("readback", N'({32'hA5C3_0F96, 1'b1}), got);
        end
        @(posedge clk);
        core_out <= {N{1'b1}};
        pad_in <= PAD;
        u_jtag_host.scan(1'b1, 6, N'(6'h20), got);
        u_jtag_host.scan(1'b0, 2, N'(2'b11), got);
        check("test_mode", N'(2'b11), N'(test_mode));
        u_jtag_host.scan(1'b1, 6, N'(6'h3D), got);
        u_jtag_host.scan(1'b0, N, PRE, got);
        check("sample", MASK | PAD & ~MASK, got);
        check("pads in sample", {N{1'b1}}, pad_out_r);
        u_jtag_host.scan(1'b1, 6, N'(6'h3E), got);
        check("extest_active", N'(1'b1), N'(extest_active));
        check("pads under extest", PRE & MASK, pad_out_r & MASK);
        u_jtag_host.scan(1'b0, N, {N{1'b0}}, got);
        check("extest capture", MASK | PAD & ~MASK, got);
        check("pads after shift", PRE & MASK, pad_out_r & MASK);
        u_jtag_host.tlr();
        check("test_mode after reset state", N'(2'b00), N'(test_mode));
        u_jtag_host.scan(1'b1, 6, N'(6'h20), got);
        u_jtag_host.scan(1'b0, 2, N'(2'b01), got);
        u_jtag_host.scan(1'b1, 6, N'(6'h3E), got);
        check("extest in reserved mode", N'(1'b0), N'(extest_active));
        conclude();
    end

    // A run that outlives its budget counts as a mismatch.
    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("unexpected run length: expected end, seen timeout");
        conclude();
    end
endmodule // tb_jtag_flash_bscan
`default_nettype wire
